/* File: rtl/left_adc_mix_map.svh */
// register offsets, field positions, reset values and decode constants of the left adc mix controls
`ifndef LEFT_ADC_MIX_MAP_SVH
`define LEFT_ADC_MIX_MAP_SVH

// printed offsets are register indexes; byte address is four times the index
`define LINE1_LEFT_IDX 8'h13
`define LINE2_LEFT_IDX 8'h14
`define LINE1_LEFT_ADDR 12'h04C
`define LINE2_LEFT_ADDR 12'h050

// field positions
`define WIRING_BIT 7
`define LEVEL_HI 6
`define LEVEL_LO 3
`define POWER_BIT 2
`define BIAS_BIT 2
`define STEP_HI 1
`define STEP_LO 0

// reset values
`define LINE1_LEFT_RESET 8'h78
`define LINE2_LEFT_RESET 8'h78

// level codes
`define LEVEL_MAX_GAIN_CODE 4'h8
`define LEVEL_OFF_CODE 4'hF

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: rtl/left_adc_mix_pkg.sv */
// types shared by the left adc input mix control block
package left_adc_mix_pkg;

    // soft-step rate of the left pga gain
    typedef enum logic [1:0] {
        STEP_EVERY_FS = 2'h0,
        STEP_EVERY_2FS = 2'h1,
        STEP_OFF_A = 2'h2,
        STEP_OFF_B = 2'h3
    } soft_step_t;

    // decoded view of one line input into the left mix
    typedef struct packed {
        logic differential;
        logic connected;
        logic [3:0] atten_steps;
    } line_route_t;

    // channel-wide controls
    typedef struct packed {
        logic powered_up;
        logic step_enable;
        logic step_every_two;
        logic weak_cm_bias;
    } channel_ctrl_t;

endpackage : left_adc_mix_pkg

/* File: rtl/left_adc_mix_ctrl.sv */
// axi4-lite register bank for the left adc input mixer controls
// Operation
// - line 1 wiring bit, resets single-ended
// - level code steps 1.5 dB attenuation
// - code 1111 disconnects line 1; reset value
// - gain code connects input automatically
// - power bit, resets powered down
// - soft-step rate: fs, 2fs, off
// - line 2 wiring bit, resets single-ended
// - line 2 level, same table, 1111 off
// - weak common-mode bias of unselected inputs
// - line 2 low bits reserved, read zero
`timescale 1ns/1ps
`default_nettype none
`include "left_adc_mix_map.svh"

module left_adc_mix_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output left_adc_mix_pkg::line_route_t line_in1_left_route,
    output left_adc_mix_pkg::line_route_t line_in2_left_route,
    output left_adc_mix_pkg::channel_ctrl_t left_channel_ctrl
);

    // held register contents
    logic [7:0] line1_left_to_left_adc_ctrl;
    logic [7:0] line2_left_to_left_adc_ctrl;

    // captured write address and data, taken in either order
    logic [11:0] wr_addr;
    logic wr_addr_held;
    logic [7:0] wr_data;
    logic wr_lane0;
    logic wr_data_held;

    // handshake events of the current cycle
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_commit;

    // decode of one level code into route fields
    function automatic left_adc_mix_pkg::line_route_t decode_route(input logic wiring, input logic [3:0] level);
        left_adc_mix_pkg::line_route_t r;
        r.differential = wiring;
        r.connected = (level <= `LEVEL_MAX_GAIN_CODE);
        // each step is 1.5 dB of attenuation; off code reports zero steps
        r.atten_steps = r.connected ? level : 4'h0;
        return r;
    endfunction : decode_route

    // soft-step code and bias bit into the channel-wide controls
    function automatic left_adc_mix_pkg::channel_ctrl_t decode_channel(
        input logic [7:0] ctl1,
        input logic [7:0] ctl2
    );
        left_adc_mix_pkg::channel_ctrl_t c;
        left_adc_mix_pkg::soft_step_t rate;
        rate = left_adc_mix_pkg::soft_step_t'(ctl1[`STEP_HI:`STEP_LO]);
        c.powered_up = ctl1[`POWER_BIT];
        // both upper codes stop stepping, so they need no separate state
        c.step_enable = (rate == left_adc_mix_pkg::STEP_EVERY_FS)
            || (rate == left_adc_mix_pkg::STEP_EVERY_2FS);
        c.step_every_two = (rate == left_adc_mix_pkg::STEP_EVERY_2FS);
        c.weak_cm_bias = ctl2[`BIAS_BIT];
        return c;
    endfunction : decode_channel

    // register selects; only the two word addresses match
    function automatic logic hits_line1(input logic [11:0] addr);
        return addr == `LINE1_LEFT_ADDR;
    endfunction : hits_line1

    function automatic logic hits_line2(input logic [11:0] addr);
        return addr == `LINE2_LEFT_ADDR;
    endfunction : hits_line2

    function automatic logic [1:0] resp_for(input logic [11:0] addr);
        // unmapped words answer with an error instead of silently
        return (hits_line1(addr) || hits_line2(addr)) ? `RESP_OKAY : `RESP_SLVERR;
    endfunction : resp_for

    // read data for one address; upper 24 bits always zero
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic [7:0] ctl1,
        input logic [7:0] ctl2
    );
        logic [31:0] word;
        word = 32'h00000000;
        if (hits_line1(addr))
        begin
            word = {24'h000000, ctl1};
        end
        else if (hits_line2(addr))
        begin
            word = {24'h000000, ctl2};
        end
        return word;
    endfunction : read_word

    // a channel moves at an edge where its valid and ready are both high
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // both halves present: store, answer and free both slots at one edge
    assign wr_commit = wr_addr_held && wr_data_held;

    // ready only while the matching slot is empty and no response pending
    assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
    assign s_axi_wready = !wr_data_held && !s_axi_bvalid;
    // one read at a time; the next address waits for the data to be taken
    assign s_axi_arready = !s_axi_rvalid;

    // write address capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_addr <= 12'h000;
            wr_addr_held <= 1'h0;
        end
        else if (aw_take)
        begin
            wr_addr <= s_axi_awaddr;
            wr_addr_held <= 1'h1;
        end
        else if (wr_commit)
        begin
            wr_addr_held <= 1'h0;
        end
    end

    // write data capture; only byte lane 0 carries register bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_data <= 8'h00;
            wr_lane0 <= 1'h0;
            wr_data_held <= 1'h0;
        end
        else if (w_take)
        begin
            wr_data <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
            wr_data_held <= 1'h1;
        end
        else if (wr_commit)
        begin
            wr_data_held <= 1'h0;
        end
    end

    // line 1 word; reserved level codes kept as written, software avoids them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line1_left_to_left_adc_ctrl <= `LINE1_LEFT_RESET;
        end
        else if (wr_commit && wr_lane0 && hits_line1(wr_addr))
        begin
            line1_left_to_left_adc_ctrl <= wr_data;
        end
    end

    // line 2 word; the two low bits are reserved and never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line2_left_to_left_adc_ctrl <= `LINE2_LEFT_RESET;
        end
        else if (wr_commit && wr_lane0 && hits_line2(wr_addr))
        begin
            line2_left_to_left_adc_ctrl <= {wr_data[7:2], 2'h0};
        end
    end

    // write response raised once both halves are in; the set wins over a clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'h0;
        end
        else if (wr_commit)
        begin
            s_axi_bvalid <= 1'h1;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'h0;
        end
    end

    // response code stands with bvalid until the master takes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (wr_commit)
        begin
            s_axi_bresp <= resp_for(wr_addr);
        end
    end

    // read valid, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'h0;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'h1;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'h0;
        end
    end

    // read data and code captured with the address so they stand unchanged
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rdata <= read_word(s_axi_araddr, line1_left_to_left_adc_ctrl, line2_left_to_left_adc_ctrl);
            s_axi_rresp <= resp_for(s_axi_araddr);
        end
    end

    // line 1 route toward the mixer, one clock behind the register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_in1_left_route <= '0;
        end
        else
        begin
            line_in1_left_route <= decode_route(line1_left_to_left_adc_ctrl[`WIRING_BIT],
                line1_left_to_left_adc_ctrl[`LEVEL_HI:`LEVEL_LO]);
        end
    end

    // line 2 route toward the mixer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_in2_left_route <= '0;
        end
        else
        begin
            line_in2_left_route <= decode_route(line2_left_to_left_adc_ctrl[`WIRING_BIT],
                line2_left_to_left_adc_ctrl[`LEVEL_HI:`LEVEL_LO]);
        end
    end

    // power, step rate and bias; registered so the analog side sees clean levels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            left_channel_ctrl <= '0;
        end
        else
        begin
            left_channel_ctrl <= decode_channel(line1_left_to_left_adc_ctrl,
                line2_left_to_left_adc_ctrl);
        end
    end

endmodule : left_adc_mix_ctrl
`default_nettype wire

/* File: tb/left_adc_mix_sva.sv */
// checker for the left adc mix control bank
`timescale 1ns/1ps
`default_nettype none
module left_adc_mix_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire left_adc_mix_pkg::line_route_t line_in1_left_route,
    input wire left_adc_mix_pkg::line_route_t line_in2_left_route,
    input wire left_adc_mix_pkg::channel_ctrl_t left_channel_ctrl
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_step_two_on: assert property (left_channel_ctrl.step_every_two |-> left_channel_ctrl.step_enable)
        else $error("step rate decode wrong");
    a_off1_zero: assert property (!line_in1_left_route.connected |-> line_in1_left_route.atten_steps == 4'h0)
        else $error("line 1 off but attenuated");
    a_on1_range: assert property (line_in1_left_route.connected |-> line_in1_left_route.atten_steps <= 4'h8)
        else $error("line 1 step out of range");
    a_off2_zero: assert property (!line_in2_left_route.connected |-> line_in2_left_route.atten_steps == 4'h0)
        else $error("line 2 off but attenuated");
    // the first edges after reset release load defaults, so they are skipped
    a_mix_hold: assert property ($changed({line_in1_left_route, line_in2_left_route, left_channel_ctrl})
        && $past(aresetn, 2) |-> $past(s_axi_bvalid))
        else $error("mixer moved without a write");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_rdata_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    cover property (line_in1_left_route.connected && line_in2_left_route.connected);
    cover property (left_channel_ctrl.powered_up && left_channel_ctrl.weak_cm_bias);
    cover property (left_channel_ctrl.step_every_two);
endmodule : left_adc_mix_sva
bind left_adc_mix_ctrl left_adc_mix_sva left_adc_mix_sva_i (.*);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the left adc mix control bank
`timescale 1ns/1ps
`default_nettype none
`include "left_adc_mix_map.svh"
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    left_adc_mix_pkg::line_route_t line_in1_left_route, line_in2_left_route;
    left_adc_mix_pkg::channel_ctrl_t left_channel_ctrl;
    logic [7:0] m1, m2;
    int failures, compares;
    left_adc_mix_ctrl left_adc_mix_ctrl_i (.*);

    // expected route: codes above 8 leave the input off
    function automatic logic [5:0] route(input logic [7:0] r);
        route = {r[7], r[6:3] <= 4'h8, (r[6:3] <= 4'h8) ? r[6:3] : 4'h0};
    endfunction : route

    // software side: no reserved level codes, zeros in reserved bits
    // wiring bits pass unchanged; the right-channel copies lie outside this bank
    function automatic logic [7:0] legal(input logic [11:0] a, input logic [7:0] d);
        legal = d;
        if (d[6:3] > 4'h8 && d[6:3] < 4'hF) legal[6:3] = 4'hF;
        if (a == `LINE2_LEFT_ADDR) legal[1:0] = 2'h0;
    endfunction : legal

    function automatic logic [3:0] ctl(input logic [7:0] a, input logic [7:0] b);
        ctl = {a[2], a[1:0] < 2'h2, a[1:0] == 2'h1, b[2]};
    endfunction : ctl

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // each channel released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // one write, then both registers and all mixer outputs compared
    task automatic step(input logic [11:0] a, input logic [7:0] d, input logic s0);
        logic ok;
        logic [7:0] v;
        ok = (a == `LINE1_LEFT_ADDR) || (a == `LINE2_LEFT_ADDR);
        v = legal(a, d);
        wr(a, {24'h0, v}, {3'h0, s0}, ok ? `RESP_OKAY : `RESP_SLVERR);
        if (ok && s0 && a == `LINE1_LEFT_ADDR) m1 = v;
        if (ok && s0 && a == `LINE2_LEFT_ADDR) m2 = v & 8'hFC;
        rd(`LINE1_LEFT_ADDR, {24'h0, m1}, `RESP_OKAY);
        rd(`LINE2_LEFT_ADDR, {24'h0, m2}, `RESP_OKAY);
        chk(line_in1_left_route, route(m1));
        chk(line_in2_left_route, route(m2));
        chk(left_channel_ctrl, ctl(m1, m2));
    endtask : step

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial
    begin
        #50000;
        failures++;
        give_verdict();
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        m1 = `LINE1_LEFT_RESET;
        m2 = `LINE2_LEFT_RESET;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        void'($urandom(32'h90CE));
        step(`LINE1_LEFT_ADDR, 8'hFF, 1'b0);
        // every level, step and power code; reserved level codes go out as off
        for (int i = 0; i < 16; i++)
        begin
            step(`LINE1_LEFT_ADDR, {i[0], i[3:0], i[2:0]}, 1'b1);
            step(`LINE2_LEFT_ADDR, {~i[0], i[3:0], i[1], 2'h3}, 1'b1);
        end
        step(12'h054, 8'h00, 1'b1);
        rd(12'h048, 32'h0, `RESP_SLVERR);
        repeat (20) step($urandom % 2 ? `LINE1_LEFT_ADDR : `LINE2_LEFT_ADDR, 8'($urandom), 1'($urandom));
        // reset again mid-run: both words and the mixer return to defaults
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        m1 = `LINE1_LEFT_RESET;
        m2 = `LINE2_LEFT_RESET;
        step(`LINE2_LEFT_ADDR, 8'h00, 1'b0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
